// *** hdl/post_reset_init_sequencer.sv ***
// host-side sequencer for the post-reset setup of a small controller
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module post_reset_init_sequencer
  import init_seq_pkg::*;
#(
  parameter int PIN_COUNT    = 64,
  parameter int SUB_WAIT_CYC = SUB_WAIT_CYC_DFLT
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [SW_AW-1:0] sw_addr,
  input  wire logic [SW_DW-1:0] sw_wdata,
  input  wire logic             sw_wr,
  input  wire logic             sw_rd,
  output logic      [SW_DW-1:0] sw_rdata,
  output logic                  dev_wr,
  output logic      [7:0]       dev_addr,
  output logic      [7:0]       dev_data,
  output logic                  init_busy,
  output logic                  init_done
);

  // ==========================================================
  // decode helpers
  function automatic logic [1:0] pin_sel(input int pc);
    case (pc)
      48:      pin_sel = 2'h1;
      40:      pin_sel = 2'h2;
      36:      pin_sel = 2'h3;
      default: pin_sel = 2'h0;
    endcase
  endfunction

  function automatic seq_state_t next_state(input seq_state_t s);
    case (s)
      ST_IDLE:   next_state = ST_STOP;
      ST_STOP:   next_state = ST_PORTS;
      ST_PORTS:  next_state = ST_SUB;
      ST_SUB:    next_state = ST_MAIN;
      ST_MAIN:   next_state = ST_FAST;
      ST_FAST:   next_state = ST_PWR;
      ST_PWR:    next_state = ST_DIV;
      ST_DIV:    next_state = ST_SWITCH;
      ST_SWITCH: next_state = ST_DONE;
      default:   next_state = ST_DONE;
    endcase
  endfunction

  // is the address one of the NUM_PORTS port registers starting at base
  function automatic logic in_port(input logic [7:0] a,
                                   input logic [7:0] base);
    in_port = (a >= base) && (a < base + 8'(NUM_PORTS));
  endfunction

  localparam logic [1:0] PSEL = pin_sel(PIN_COUNT);

  // ==========================================================
  // software registers
  logic [1:0]  module_stop_setting;
  logic [15:0] clk_cfg;
  logic [15:0] div_cfg;
  logic        start_req;
  logic        port_refused;
  logic        port_pend;
  logic [7:0]  port_addr;
  logic [7:0]  port_data;
  seq_state_t  state;

  wire logic       sub_use  = clk_cfg[CFG_SUB];
  wire logic       main_use = clk_cfg[CFG_MAIN];
  wire logic       fast_use = clk_cfg[CFG_FAST];
  wire logic [1:0] clk_src  = clk_cfg[CFG_SRC_LO+:2];
  wire logic [1:0] pwr_mode = clk_cfg[CFG_PWR_LO+:2];

  wire logic       sw_w_port = sw_wr && (sw_addr == SW_PORTWR);
  wire logic [3:0] pw_idx    = sw_wdata[PW_IDX_LO+:4];
  wire logic       pw_ok     = (state == ST_DONE) &&
                               (pw_idx < 4'(NUM_PORTS));
  wire logic       clr_err   = sw_wr && (sw_addr == SW_CTRL) &&
                               sw_wdata[CTRL_CLRERR];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      module_stop_setting <= MSTOP_RST;
      clk_cfg             <= CLKCFG_RST;
      div_cfg             <= DIVCFG_RST;
    end else if (sw_wr && state == ST_IDLE) begin
      // settings freeze once the run has started
      case (sw_addr)
        SW_MSTOP:  module_stop_setting <= sw_wdata[1:0];
        SW_CLKCFG: clk_cfg             <= sw_wdata;
        SW_DIVCFG: div_cfg             <= sw_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_req <= 1'b0;
    end else begin
      start_req <= sw_wr && (sw_addr == SW_CTRL) &&
                   sw_wdata[CTRL_START] && (state == ST_IDLE);
    end
  end

  // later port writes from software get the absent-pin bits forced
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port_pend <= 1'b0;
      port_addr <= 8'h00;
      port_data <= 8'h00;
    end else begin
      port_pend <= sw_w_port && pw_ok;
      if (sw_w_port && pw_ok) begin
        if (sw_wdata[PW_OUT]) begin
          port_addr <= DEV_OUT_BASE + {4'h0, pw_idx};
          port_data <= sw_wdata[7:0] & ~NX_MASK[PSEL][pw_idx];
        end else begin
          port_addr <= DEV_DIR_BASE + {4'h0, pw_idx};
          port_data <= (sw_wdata[7:0] & ~NX_MASK[PSEL][pw_idx]) |
                       (NX_DIR[PSEL][pw_idx] &
                        NX_MASK[PSEL][pw_idx]);
        end
      end
    end
  end

  // a refused port write sets the flag; the set wins over a clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port_refused <= 1'b0;
    end else if (sw_w_port && !pw_ok) begin
      port_refused <= 1'b1;
    end else if (clr_err) begin
      port_refused <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sw_rdata <= 16'h0000;
    end else if (sw_rd) begin
      case (sw_addr)
        SW_MSTOP:  sw_rdata <= {14'h0000, module_stop_setting};
        SW_CLKCFG: sw_rdata <= clk_cfg;
        SW_DIVCFG: sw_rdata <= div_cfg;
        SW_STATUS: sw_rdata <= {8'h00, state, 1'b0, port_refused,
                                init_busy, init_done};
        default:   sw_rdata <= 16'h0000;
      endcase
    end else begin
      sw_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // step decode: what the current step and op index write
  logic [4:0]  op;
  logic        op_wr;
  logic [7:0]  op_addr;
  logic [7:0]  op_data;
  logic        op_wait;
  logic [31:0] op_wlen;
  logic        op_last;
  logic [3:0]  op_port;
  logic        tmr_busy;

  always_comb begin
    op_wr   = 1'b0;
    op_addr = 8'h00;
    op_data = 8'h00;
    op_wait = 1'b0;
    op_wlen = 32'h0000_0000;
    op_last = 1'b0;
    op_port = op[4:1];
    case (state)
      ST_STOP: begin
        op_last = (op == 5'h01);
        op_data = MSTOP_BYTE_STOP;
        if (op == 5'h00) begin
          op_wr   = module_stop_setting[0];
          op_addr = DEV_MSTOP_A3;
        end else begin
          op_wr   = module_stop_setting[1];
          op_addr = DEV_MSTOP_C0;
        end
      end
      ST_PORTS: begin
        op_last = (op == PORT_OP_END);
        op_wr   = (NX_MASK[PSEL][op_port] != 8'h00);
        if (op[0]) begin
          op_addr = DEV_OUT_BASE + {4'h0, op_port};
          op_data = 8'h00;
        end else begin
          op_addr = DEV_DIR_BASE + {4'h0, op_port};
          op_data = NX_DIR[PSEL][op_port];
        end
      end
      ST_SUB: begin
        // the sub-clock runs from power-on, so it is always reset
        op_last = (op == 5'h01);
        op_addr = DEV_SUB_CTRL;
        if (op == 5'h00) begin
          op_wr   = 1'b1;
          op_data = OSC_STOP;
        end else begin
          op_wr   = sub_use;
          op_data = OSC_RUN;
          op_wait = sub_use;
          op_wlen = 32'(SUB_WAIT_CYC);
        end
      end
      ST_MAIN: begin
        op_last = (op == 5'h02);
        op_wr   = main_use;
        case (op)
          5'h00: begin
            op_addr = DEV_MAIN_DRV;
            op_data = MAIN_DRV_VAL;
          end
          5'h01: begin
            op_addr = DEV_MAIN_WAIT;
            op_data = MAIN_WAIT_VAL;
          end
          default: begin
            op_addr = DEV_MAIN_CTRL;
            op_data = OSC_RUN;
          end
        endcase
      end
      ST_FAST: begin
        op_last = (op == 5'h01);
        op_wr   = fast_use;
        if (op == 5'h00) begin
          op_addr = DEV_FAST_WAIT;
          op_data = FAST_WAIT_VAL;
        end else begin
          op_addr = DEV_FAST_CTRL;
          op_data = OSC_RUN;
          op_wait = fast_use;
          op_wlen = 32'(FAST_WAIT_CYC);
        end
      end
      ST_PWR: begin
        op_last = 1'b1;
        op_wr   = 1'b1;
        op_addr = DEV_PWR_MODE;
        op_data = {6'h00, pwr_mode};
      end
      ST_DIV: begin
        op_last = (op == 5'h01);
        op_wr   = 1'b1;
        op_addr = op[0] ? DEV_DIV_HI : DEV_DIV_LO;
        op_data = op[0] ? div_cfg[15:8] : div_cfg[7:0];
      end
      ST_SWITCH: begin
        op_last = 1'b1;
        op_wr   = 1'b1;
        op_addr = DEV_CLK_SRC;
        op_data = {6'h00, clk_src};
      end
      default: ;
    endcase
  end

  wire logic active  = (state != ST_IDLE) && (state != ST_DONE);
  wire logic advance = active && !tmr_busy;

  seq_wait_timer u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (advance && op_wait),
    .load_val (op_wlen),
    .busy     (tmr_busy)
  );

  // ==========================================================
  // step sequencing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op    <= 5'h00;
    end else if (state == ST_IDLE) begin
      if (start_req) begin
        state <= next_state(state);
      end
    end else if (advance) begin
      if (op_last) begin
        state <= next_state(state);
        op    <= 5'h00;
      end else begin
        op    <= op + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      init_busy <= 1'b0;
      init_done <= 1'b0;
    end else begin
      // busy must drop for good once the run has reached done
      init_busy <= (state == ST_IDLE) ? start_req :
                   (state != ST_DONE) && !(advance && state == ST_SWITCH);
      if (advance && state == ST_SWITCH) begin
        init_done <= 1'b1;
      end
    end
  end

  // ==========================================================
  // device write port; the run and software port writes never
  // overlap, since software writes are taken only when done
  seq_state_t wr_state;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dev_wr   <= 1'b0;
      dev_addr <= 8'h00;
      dev_data <= 8'h00;
      wr_state <= ST_IDLE;
    end else begin
      dev_wr <= 1'b0;
      if (advance && op_wr) begin
        dev_wr   <= 1'b1;
        dev_addr <= op_addr;
        dev_data <= op_data;
        wr_state <= state;
      end else if (port_pend) begin
        dev_wr   <= 1'b1;
        dev_addr <= port_addr;
        dev_data <= port_data;
        wr_state <= state;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_stop_write_gated: assert property (
    dev_wr && (dev_addr == DEV_MSTOP_A3 || dev_addr == DEV_MSTOP_C0)
    |-> (dev_addr == DEV_MSTOP_A3) ? module_stop_setting[0]
                                   : module_stop_setting[1])
    else $error("module stop written while setting is 0");

  a_port_dir_fixed: assert property (
    dev_wr && in_port(dev_addr, DEV_DIR_BASE)
    |-> (dev_data & NX_MASK[PSEL][4'(dev_addr - DEV_DIR_BASE)]) ==
        (NX_DIR[PSEL][4'(dev_addr - DEV_DIR_BASE)] &
         NX_MASK[PSEL][4'(dev_addr - DEV_DIR_BASE)]))
    else $error("absent-pin direction bits wrong");

  a_port_out_zero: assert property (
    dev_wr && in_port(dev_addr, DEV_OUT_BASE)
    |-> (dev_data & NX_MASK[PSEL][4'(dev_addr - DEV_OUT_BASE)]) ==
        8'h00)
    else $error("absent-pin output bit not zero");

  a_step_order: assert property (
    (state != $past(state)) |-> state == next_state($past(state)))
    else $error("clock steps out of order");

  a_sub_reset_first: assert property (
    advance && state == ST_SUB && op == 5'h00
    |=> dev_wr && dev_addr == DEV_SUB_CTRL && dev_data == OSC_STOP)
    else $error("sub-clock control not reset first");

  a_sub_settle_wait: assert property (
    dev_wr && dev_addr == DEV_SUB_CTRL && dev_data == OSC_RUN
    |=> !dev_wr [*8])
    else $error("write during sub-clock settling");

  a_main_order: assert property (
    dev_wr && dev_addr == DEV_MAIN_CTRL
    |-> $past(dev_wr && dev_addr == DEV_MAIN_WAIT) &&
        $past(dev_addr == DEV_MAIN_DRV, 2))
    else $error("main clock enabled out of order");

  a_fast_order: assert property (
    dev_wr && dev_addr == DEV_FAST_CTRL
    |-> $past(dev_wr && dev_addr == DEV_FAST_WAIT)
    ##1 tmr_busy)
    else $error("fast oscillator enabled out of order");

  a_unused_quiet: assert property (
    dev_wr |-> !((wr_state == ST_MAIN && !main_use) ||
                 (wr_state == ST_FAST && !fast_use)))
    else $error("write from an unused oscillator step");

  a_pwr_before_div: assert property (
    dev_wr && dev_addr == DEV_DIV_LO
    |-> $past(dev_wr && dev_addr == DEV_PWR_MODE) ##1
        dev_wr && dev_addr == DEV_DIV_HI)
    else $error("dividers set before power mode");

  a_done_on_switch: assert property (
    dev_wr && dev_addr == DEV_CLK_SRC && wr_state == ST_SWITCH
    |-> init_done && state == ST_DONE ##1 init_done)
    else $error("done flag not raised with clock switch");

  c_run_done: cover property ($rose(init_done));
  c_sub_used: cover property (dev_wr && dev_addr == DEV_SUB_CTRL &&
                              dev_data == OSC_RUN);
  c_fast_used: cover property (dev_wr && dev_addr == DEV_FAST_CTRL);
  c_port_after: cover property (dev_wr && wr_state == ST_DONE);

endmodule

// *** inc/init_seq_pkg.sv ***
// constants and types shared by the post-reset init sequencer
package init_seq_pkg;

  // ==========================================================
  // software-side register port
  localparam int              SW_AW       = 4;
  localparam int              SW_DW       = 16;
  localparam logic [3:0]      SW_CTRL     = 4'h0;
  localparam logic [3:0]      SW_MSTOP    = 4'h1;
  localparam logic [3:0]      SW_CLKCFG   = 4'h2;
  localparam logic [3:0]      SW_DIVCFG   = 4'h3;
  localparam logic [3:0]      SW_PORTWR   = 4'h4;
  localparam logic [3:0]      SW_STATUS   = 4'h5;

  // control bits
  localparam int              CTRL_START  = 0;
  localparam int              CTRL_CLRERR = 1;

  // clock config fields
  localparam int              CFG_SUB     = 0;
  localparam int              CFG_MAIN    = 1;
  localparam int              CFG_FAST    = 2;
  localparam int              CFG_SRC_LO  = 3;
  localparam int              CFG_PWR_LO  = 5;
  localparam logic [1:0]      SRC_SLOW    = 2'h0;
  localparam logic [1:0]      SRC_FAST    = 2'h1;
  localparam logic [1:0]      SRC_MAIN    = 2'h2;
  localparam logic [1:0]      SRC_SUB     = 2'h3;
  localparam logic [1:0]      PWR_HIGH    = 2'h0;

  // port write request fields
  localparam int              PW_IDX_LO   = 8;
  localparam int              PW_OUT      = 12;

  // reset values: nothing stopped, main clock on and selected,
  // high-speed power mode, every divider at divide-by-1 (code 0)
  localparam logic [1:0]      MSTOP_RST   = 2'h0;
  localparam logic [15:0]     CLKCFG_RST  = 16'h0012;
  localparam logic [15:0]     DIVCFG_RST  = 16'h0000;

  // ==========================================================
  // device register map on the write port
  localparam logic [7:0]      DEV_DIR_BASE  = 8'h00;
  localparam logic [7:0]      DEV_OUT_BASE  = 8'h20;
  localparam logic [7:0]      DEV_MSTOP_A3  = 8'h40;
  localparam logic [7:0]      DEV_MSTOP_C0  = 8'h44;
  localparam logic [7:0]      DEV_SUB_CTRL  = 8'h50;
  localparam logic [7:0]      DEV_MAIN_DRV  = 8'h51;
  localparam logic [7:0]      DEV_MAIN_WAIT = 8'h52;
  localparam logic [7:0]      DEV_MAIN_CTRL = 8'h53;
  localparam logic [7:0]      DEV_FAST_WAIT = 8'h54;
  localparam logic [7:0]      DEV_FAST_CTRL = 8'h55;
  localparam logic [7:0]      DEV_PWR_MODE  = 8'h56;
  localparam logic [7:0]      DEV_DIV_LO    = 8'h57;
  localparam logic [7:0]      DEV_DIV_HI    = 8'h58;
  localparam logic [7:0]      DEV_CLK_SRC   = 8'h59;

  // other stop bits in those bytes are already 1 after reset
  localparam logic [7:0]      MSTOP_BYTE_STOP = 8'hFF;
  localparam logic [7:0]      MAIN_DRV_VAL    = 8'h20;
  localparam logic [7:0]      MAIN_WAIT_VAL   = 8'h06;
  localparam logic [7:0]      FAST_WAIT_VAL   = 8'h06;
  localparam logic [7:0]      OSC_STOP        = 8'h01;
  localparam logic [7:0]      OSC_RUN         = 8'h00;

  // ==========================================================
  // absent-pin tables, [package][port]; ports 0..5,A,B,C,E,H,J
  localparam int              NUM_PORTS   = 12;
  localparam logic [4:0]      PORT_OP_END = 5'h17;
  localparam logic [7:0] NX_MASK [4][12] = '{
    '{8'hD7, 8'h0F, 8'h3F, 8'hF8, 8'hA0, 8'hCF,
      8'hA4, 8'h14, 8'h00, 8'h00, 8'hF0, 8'h3F},
    '{8'hFF, 8'h0F, 8'h3F, 8'hFF, 8'hA0, 8'hFF,
      8'hA5, 8'h54, 8'h00, 8'h60, 8'hF0, 8'h3F},
    '{8'hFF, 8'h0F, 8'h3F, 8'hFB, 8'hB9, 8'hFF,
      8'hA5, 8'hF6, 8'hEF, 8'hE0, 8'hF0, 8'h3F},
    '{8'hFF, 8'h0F, 8'h7F, 8'hFF, 8'hF9, 8'hFF,
      8'hA7, 8'hF6, 8'hEF, 8'hE0, 8'hF0, 8'h3F}};
  localparam logic [7:0] NX_DIR [4][12] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h28, 8'h00, 8'h00, 8'h07, 8'h00, 8'h30,
      8'h01, 8'h40, 8'h00, 8'h60, 8'h00, 8'h00},
    '{8'h28, 8'h00, 8'h00, 8'h03, 8'h19, 8'h30,
      8'h01, 8'hE2, 8'hEF, 8'hE0, 8'h00, 8'h00},
    '{8'h28, 8'h00, 8'h40, 8'h07, 8'h59, 8'h30,
      8'h03, 8'hE2, 8'hEF, 8'hE0, 8'h00, 8'h00}};

  // ==========================================================
  // timing at 50 MHz
  localparam int              CLK_KHZ          = 50000;
  localparam int              SUB_SETTLE_MS    = 1310;
  localparam int              SUB_WAIT_CYC_DFLT = SUB_SETTLE_MS * CLK_KHZ;
  localparam int              FAST_SETTLE_US   = 50;
  localparam int              FAST_WAIT_CYC    =
    FAST_SETTLE_US * CLK_KHZ / 1000;

  // ==========================================================
  // sequencer states, gray along the run
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_STOP   = 4'h1,
    ST_PORTS  = 4'h3,
    ST_SUB    = 4'h2,
    ST_MAIN   = 4'h6,
    ST_FAST   = 4'h7,
    ST_PWR    = 4'h5,
    ST_DIV    = 4'h4,
    ST_SWITCH = 4'hC,
    ST_DONE   = 4'hD
  } seq_state_t;

endpackage

// *** hdl/seq_wait_timer.sv ***
// down-counter that holds the sequencer during oscillator settling
`timescale 1ns/100ps
module seq_wait_timer (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  output logic             busy
);

  logic [31:0] count;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
    end else if (load) begin
      count <= load_val;
    end else if (count != 32'h0000_0000) begin
      count <= count - 32'h0000_0001;
    end
  end

  assign busy = (count != 32'h0000_0000);

endmodule

// *** tb/init_dev_model.sv ***
// behavioural model of the configured device's system registers
`timescale 1ns/100ps
module init_dev_model
  import init_seq_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       dev_wr,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_data
);
  // ==========================================================
  // state kept by the device
  logic [15:0] log_q [$];
  logic        xfer_stop;
  logic        ram_stop;
  logic        sub_run;
  logic [7:0]  port_dir [12];
  logic [7:0]  port_out [12];

  // ==========================================================
  // register file; every write is logged for the bench to compare
  always @(posedge core_clk) begin
    if (!rst_n) begin
      xfer_stop <= 1'b0;
      ram_stop  <= 1'b0;
      sub_run   <= 1'b1;
    end else if (dev_wr) begin
      log_q.push_back({dev_addr, dev_data});
      if (dev_addr == DEV_MSTOP_A3) begin
        xfer_stop <= dev_data[4];
      end
      if (dev_addr == DEV_MSTOP_C0) begin
        ram_stop <= dev_data[0];
      end
      if (dev_addr == DEV_SUB_CTRL) begin
        sub_run <= ~dev_data[0];
      end
      if (dev_addr < DEV_DIR_BASE + 8'(NUM_PORTS)) begin
        port_dir[dev_addr[3:0]] <= dev_data;
      end
      if (dev_addr >= DEV_OUT_BASE &&
          dev_addr < DEV_OUT_BASE + 8'(NUM_PORTS)) begin
        port_out[dev_addr[3:0]] <= dev_data;
      end
    end
  end
endmodule

// *** tb/post_reset_init_sequencer_test.sv ***
// self-checking bench for the post-reset init sequencer
`timescale 1ns/100ps
module post_reset_init_sequencer_test;
  import init_seq_pkg::*;
  typedef struct {
    logic [3:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] e;
  } row_t;
  logic             core_clk;
  logic             rst_n;
  logic [SW_AW-1:0] sw_addr;
  logic [SW_DW-1:0] sw_wdata;
  logic             sw_wr;
  logic             sw_rd;
  logic [SW_DW-1:0] sw_rdata;
  logic             dev_wr;
  logic [7:0]       dev_addr;
  logic [7:0]       dev_data;
  logic             init_busy;
  logic             init_done;
  int               n_mismatch;
  int               total_checks;
  int               n0;
  logic [15:0]      v;
  logic [15:0]      exp_q [$];
  row_t             rows [8];

  post_reset_init_sequencer #(.PIN_COUNT(64), .SUB_WAIT_CYC(16))
    post_reset_init_sequencer_inst (.core_clk(core_clk), .rst_n(rst_n),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .dev_wr(dev_wr), .dev_addr(dev_addr),
    .dev_data(dev_data), .init_busy(init_busy), .init_done(init_done));
  init_dev_model init_dev_model_inst (.core_clk(core_clk), .rst_n(rst_n),
    .dev_wr(dev_wr), .dev_addr(dev_addr), .dev_data(dev_data));

  // ==========================================================
  // bus tasks and comparison
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic push_ports();
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (NX_MASK[0][i] != 8'h00) begin
        exp_q.push_back({DEV_DIR_BASE + 8'(i), NX_DIR[0][i]});
        exp_q.push_back({DEV_OUT_BASE + 8'(i), 8'h00});
      end
    end
  endtask
  task automatic wait_done();
    for (int i = 0; i < 10000 && init_done !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    repeat (2) @(posedge core_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    sw_addr = '0;
    sw_wdata = '0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    rows = '{'{SW_MSTOP, 0, 16'h0000, 16'h0000},
             '{SW_CLKCFG, 0, 16'h0000, 16'h0012},
             '{SW_DIVCFG, 0, 16'h0000, 16'h0000},
             '{SW_STATUS, 0, 16'h0000, 16'h0000},
             '{SW_MSTOP, 1, 16'h0003, 16'h0003},
             '{SW_CLKCFG, 1, 16'h000F, 16'h000F},
             '{SW_DIVCFG, 1, 16'h1234, 16'h1234},
             '{4'hF, 1, 16'h0055, 16'h0000}};
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // port write before the run is refused and reaches nothing
    wr(SW_PORTWR, 16'h10FF);
    rd(SW_STATUS, v);
    chk(v, 16'h0004);
    wr(SW_CTRL, 16'h0002);
    rd(SW_STATUS, v);
    chk(v, 16'h0000);
    chk(16'(init_dev_model_inst.log_q.size()), 16'h0000);
    // all three oscillators used, fast selected, raw divider codes
    exp_q = '{{DEV_MSTOP_A3, 8'hFF}, {DEV_MSTOP_C0, 8'hFF}};
    push_ports();
    exp_q.push_back({DEV_SUB_CTRL, OSC_STOP});
    exp_q.push_back({DEV_SUB_CTRL, OSC_RUN});
    exp_q.push_back({DEV_MAIN_DRV, 8'h20});
    exp_q.push_back({DEV_MAIN_WAIT, 8'h06});
    exp_q.push_back({DEV_MAIN_CTRL, OSC_RUN});
    exp_q.push_back({DEV_FAST_WAIT, 8'h06});
    exp_q.push_back({DEV_FAST_CTRL, OSC_RUN});
    exp_q.push_back({DEV_PWR_MODE, 8'h00});
    exp_q.push_back({DEV_DIV_LO, 8'h34});
    exp_q.push_back({DEV_DIV_HI, 8'h12});
    exp_q.push_back({DEV_CLK_SRC, 6'h00, SRC_FAST});
    wr(SW_CTRL, 16'h0001);
    @(posedge core_clk);
    #1 chk(16'(init_busy), 16'h0001);
    // settings are frozen once the run is under way
    wr(SW_MSTOP, 16'h0000);
    rd(SW_MSTOP, v);
    chk(v, 16'h0003);
    wait_done();
    chk(16'(init_dev_model_inst.log_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) begin
      chk(init_dev_model_inst.log_q[i], exp_q[i]);
    end
    chk(16'({init_dev_model_inst.xfer_stop,
             init_dev_model_inst.ram_stop}), 16'h0003);
    // later port bytes keep the absent-pin bits
    wr(SW_PORTWR, 16'h10FF);
    wr(SW_PORTWR, 16'h03FF);
    wr(SW_PORTWR, 16'h0CFF);
    repeat (3) @(posedge core_clk);
    chk(init_dev_model_inst.log_q[exp_q.size()],
        {DEV_OUT_BASE, 8'h28});
    chk(init_dev_model_inst.log_q[exp_q.size() + 1],
        {DEV_DIR_BASE + 8'h03, 8'h07});
    chk(16'(init_dev_model_inst.log_q.size()),
        16'(exp_q.size() + 2));
    rd(SW_STATUS, v);
    chk(v, {8'h00, 4'(ST_DONE), 4'h5});
    chk(16'(init_dev_model_inst.port_out[0]), 16'h0028);
    chk(16'(init_dev_model_inst.sub_run), 16'h0001);
    // second reset: outputs clear, settings back to defaults
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1 chk(16'({init_busy, init_done, dev_wr}), 16'h0000);
    rd(SW_STATUS, v);
    chk(v, 16'h0000);
    rd(SW_CLKCFG, v);
    chk(v, CLKCFG_RST);
    // default run: no stop writes, sub only stopped, fast step quiet
    exp_q.delete();
    push_ports();
    exp_q.push_back({DEV_SUB_CTRL, OSC_STOP});
    exp_q.push_back({DEV_MAIN_DRV, MAIN_DRV_VAL});
    exp_q.push_back({DEV_MAIN_WAIT, MAIN_WAIT_VAL});
    exp_q.push_back({DEV_MAIN_CTRL, OSC_RUN});
    exp_q.push_back({DEV_PWR_MODE, 6'h00, PWR_HIGH});
    exp_q.push_back({DEV_DIV_LO, 8'h00});
    exp_q.push_back({DEV_DIV_HI, 8'h00});
    exp_q.push_back({DEV_CLK_SRC, 6'h00, SRC_MAIN});
    n0 = init_dev_model_inst.log_q.size();
    wr(SW_CTRL, 16'h0001);
    wait_done();
    chk(16'(init_dev_model_inst.log_q.size() - n0),
        16'(exp_q.size()));
    foreach (exp_q[i]) begin
      chk(init_dev_model_inst.log_q[n0 + i], exp_q[i]);
    end
    chk(16'({init_dev_model_inst.xfer_stop, init_dev_model_inst.ram_stop,
             init_dev_model_inst.sub_run}), 16'h0000);
    report_and_stop();
  end
endmodule
